// ### verif/oad_bus_model.sv
// Far-side bus model: ready stall count seen on an operand access.
`timescale 1ns/1ns
module oad_bus_model #(
    parameter int WAIT_EXT = 3
) (
    input  wire oad_pkg::oad_loc_t loc,
    output logic [7:0]             wait_cycles
);
    import oad_pkg::*;
    // Only the external bus stalls on ready; internal space never waits.
    assign wait_cycles = (loc == OAD_LOC_EXT16 || loc == OAD_LOC_EXT8) ?
                         8'(WAIT_EXT) : 8'h00;
endmodule

// ### verif/oad_top_test.sv
// Self-checking bench for the operand decode and cycle cost engine.
`timescale 1ns/1ns
module oad_top_test;
    import oad_pkg::*;
    localparam int WT = 3;
    logic        clock, rstn, clk_en, req_valid, intermittent_en;
    logic        req_ready, rmw_active, busy, done;
    oad_req_t    req;
    oad_ea_t     ea_info;
    oad_loc_t    bus_loc;
    logic [9:0]  total_cycles;
    logic [4:0]  total_rg;
    logic [3:0]  total_accesses;
    logic [31:0] acc;
    logic [23:0] io_addr;
    logic [15:0] sign_ext_short_imm, reg_access_count, rg_sum;
    logic [7:0]  vector_num, wait_cycles;
    int          n_fail, compares;

    oad_top i_dut (.clock(clock), .rstn(rstn), .clk_en(clk_en),
        .req_valid(req_valid), .req(req), .intermittent_en(intermittent_en),
        .req_ready(req_ready), .ea_info(ea_info), .total_rg(total_rg),
        .total_cycles(total_cycles), .total_accesses(total_accesses),
        .rmw_active(rmw_active), .acc(acc), .io_addr(io_addr),
        .sign_ext_short_imm(sign_ext_short_imm), .vector_num(vector_num),
        .busy(busy), .done(done), .reg_access_count(reg_access_count));
    oad_bus_model #(.WAIT_EXT(WT)) i_bus (.loc(bus_loc),
        .wait_cycles(wait_cycles));

    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    function automatic logic [11:0] ea_exp(logic [4:0] c);
        if (c < 5'h08) return {OAD_MODE_REG, 9'h000};
        if (c < 5'h0C) return {OAD_MODE_INDIRECT, 2'h0, 4'h2, 3'h1};
        if (c < 5'h10) return {OAD_MODE_POSTINC, 2'h0, 4'h4, 3'h2};
        if (c < 5'h18) return {OAD_MODE_SHORT_DISPLACEMENT, 2'h1, 4'h2, 3'h1};
        if (c < 5'h1C) return {OAD_MODE_LONG_DISPLACEMENT, 2'h2, 4'h2, 3'h1};
        if (c < 5'h1E) return {OAD_MODE_INDEXED, 2'h0, 4'h4, 3'h2};
        if (c == 5'h1E) return {OAD_MODE_PC_DISP, 2'h2, 4'h2, 3'h0};
        return {OAD_MODE_DIRECT, 2'h2, 4'h1, 3'h0};
    endfunction

    // Caller stands one delay past an edge with the engine idle.
    task automatic run_req(oad_req_t r, logic [9:0] ecyc);
        int k;
        logic [11:0] e;
        logic [4:0] g;
        e = ea_exp(r.ea_code);
        req = r;
        req_valid = 1'b1;
        @(posedge clock);
        #1 req_valid = 1'b0;
        g = 5'(r.instr_rg);
        if (r.ea_code >= 5'h08) g = g + 5'(e[2:0]);
        rg_sum = rg_sum + 16'(g);
        chk("total_rg", 32'(g), 32'(total_rg));
        chk("busy_ready", 32'h2, 32'({busy, req_ready}));
        chk("total_cycles", 32'(ecyc), 32'(total_cycles));
        k = 0;
        while (done !== 1'b1 && k < 300) begin
            @(posedge clock);
            #1 k++;
        end
        chk("done_delay", 32'(ecyc), 32'(k));
        @(posedge clock);
        #1 chk("rg_count", 32'(rg_sum), 32'(reg_access_count));
        chk("idle", 32'h1, 32'({busy, req_ready}));
    endtask

    task automatic test_decode;
        logic [11:0] g;
        logic [10:0] x, y;
        for (int c = 0; c < 32; c++) begin
            @(posedge clock);
            #1 req.ea_code = 5'(c);
            #4 g = {ea_info.mode, ea_info.ext_bytes, ea_info.cycles,
                    ea_info.rg};
            y = {ea_info.byte_reg_n, ea_info.word_reg_n, ea_info.long_reg_n,
                 ea_info.low_word_reg_n, ea_info.index_used};
            x = {c[2:0], c[2:0], c[2:1], c[1:0], 1'b0};
            if (c == 28 || c == 29) x[2:0] = {2'(c[0]), 1'b1};
            chk("ea", 32'(ea_exp(5'(c))), 32'(g));
            chk("ea_regs", 32'(x), 32'(y));
            chk("reg_direct", 32'(c < 8), 32'(ea_info.reg_direct));
        end
        @(posedge clock);
        #1 $display("test_decode done");
    endtask

    task automatic test_cost;
        oad_req_t r;
        logic [3:0] cr, ac, fu;
        logic slow;
        for (int w = 0; w < 3; w++)
        for (int l = 0; l < 4; l++)
        for (int o = 0; o < 2; o++) begin
            if (l == 0 && o == 1) continue;
            r = '0;
            r.ea_code = 5'h1F;
            r.width = oad_width_t'(w);
            r.loc = oad_loc_t'(l);
            r.odd_addr = 1'(o);
            r.instr_cycles = 8'h02;
            r.fetch_bounds = 4'h1;
            bus_loc = r.loc;
            @(posedge clock);
            #1 r.wait_cycles = wait_cycles;
            slow = (l == 3) || (o == 1 && l != 0);
            ac = slow ? 4'(1 << w) : ((w == 2) ? 4'h2 : 4'h1);
            cr = 4'h0;
            if (l >= 2) cr = (w == 2) ? 4'h2 : 4'h1;
            if (l >= 2 && slow) cr = (w == 0) ? 4'h1 : 4'(4 * w);
            if (l == 1 && o == 1) cr = 4'(2 * w);
            fu = (l == 0) ? 4'h0 : ((l == 1) ? 4'h2 : 4'h3);
            run_req(r, 10'(3 + cr + fu + ((l >= 2) ? WT : 0)));
            chk("accesses", 32'(ac), 32'(total_accesses));
        end
        $display("test_cost done");
    endtask

    task automatic acc_step(oad_width_t w, oad_lh_t lh, oad_ah_t ah,
                            logic [31:0] d, logic [31:0] e);
        oad_req_t r;
        r = '0;
        r.width = w;
        r.lh = lh;
        r.ah = ah;
        r.load_data = d;
        r.load_acc = 1'b1;
        r.instr_cycles = 8'h01;
        run_req(r, 10'h001);
        chk("acc", e, acc);
    endtask

    task automatic test_acc;
        acc_step(OAD_LONG, OAD_LH_KEEP, OAD_AH_KEEP, 32'h12348765, 32'h12348765);
        acc_step(OAD_BYTE, OAD_LH_ZERO, OAD_AH_COPY, 32'h000000A5, 32'h876500A5);
        acc_step(OAD_BYTE, OAD_LH_SIGN, OAD_AH_KEEP, 32'h00000080, 32'h8765FF80);
        acc_step(OAD_BYTE, OAD_LH_KEEP, OAD_AH_CLEAR, 32'h00000011, 32'h0000FF11);
        acc_step(OAD_WORD, OAD_LH_KEEP, OAD_AH_SIGN, 32'h00008001, 32'hFFFF8001);
        acc_step(OAD_WORD, OAD_LH_KEEP, OAD_AH_SIGN, 32'h00007001, 32'h00007001);
        $display("test_acc done");
    endtask

    task automatic test_misc;
        oad_req_t r;
        r = '0;
        r.ea_code = 5'h0C;
        r.instr_rg = 4'h3;
        r.loc = OAD_LOC_EXT16;
        r.width = OAD_WORD;
        r.read_mod_write_class = 1'b1;
        r.instr_cycles = 8'h02;
        r.io_offset = 8'hC3;
        r.imm8 = 8'h9A;
        r.vct_field = 8'hF7;
        bus_loc = r.loc;
        intermittent_en = 1'b1;
        @(posedge clock);
        #1 r.wait_cycles = wait_cycles;
        run_req(r, 10'd16);
        chk("rmw_active", 32'h1, 32'(rmw_active));
        chk("accesses", 32'h2, 32'(total_accesses));
        chk("io_addr", 32'h0000C3, 32'(io_addr));
        chk("sx_imm", 32'hFF9A, 32'(sign_ext_short_imm));
        chk("vector", 32'h07, 32'(vector_num));
        // Register operand under a read-modify-write instruction.
        r = '0;
        r.ea_code = 5'h03;
        r.read_mod_write_class = 1'b1;
        r.instr_cycles = 8'h02;
        r.imm8 = 8'h7F;
        r.vct_long = 1'b1;
        r.vct_field = 8'hF7;
        intermittent_en = 1'b0;
        run_req(r, 10'd2);
        chk("rmw_active", 32'h0, 32'(rmw_active));
        chk("sx_imm", 32'h007F, 32'(sign_ext_short_imm));
        chk("vector", 32'hF7, 32'(vector_num));
        chk("io_addr", 32'h0, 32'(io_addr));
        $display("test_misc done");
    endtask

    task automatic test_freeze;
        oad_req_t r;
        r = '0;
        r.width = OAD_LONG;
        r.load_acc = 1'b1;
        r.load_data = 32'h5A5AC3C3;
        r.instr_cycles = 8'h03;
        clk_en = 1'b0;
        req = r;
        req_valid = 1'b1;
        repeat (4) @(posedge clock);
        #1 chk("frozen_acc", 32'h00007001, acc);
        chk("frozen_ready", 32'h1, 32'(req_ready));
        clk_en = 1'b1;
        run_req(r, 10'd3);
        chk("acc", 32'h5A5AC3C3, acc);
        $display("test_freeze done");
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (6000) @(posedge clock);
        n_fail++;
        test_done;
    end

    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        intermittent_en = 1'b0;
        req = '0;
        bus_loc = OAD_LOC_IREG;
        n_fail = 0;
        compares = 0;
        rg_sum = 16'h0000;
        repeat (20) @(posedge clock);
        #1 rstn = 1'b1;
        chk("ready_reset", 32'h1, 32'(req_ready));
        chk("acc_reset", 32'h0, acc);
        test_decode;
        test_cost;
        test_acc;
        test_misc;
        test_freeze;
        test_done;
    end
endmodule

// ### verilog/oad_access_cost.sv
// Per-access cycle correction by width, location and address parity.
`timescale 1ns/1ns
module oad_access_cost (
    input  wire oad_pkg::oad_width_t width,
    input  wire oad_pkg::oad_loc_t   loc,
    input  wire logic                odd_addr,
    output oad_pkg::oad_cost_t       cost
);
    import oad_pkg::*;

    wire is_long  = width == OAD_LONG;
    wire is_word  = width == OAD_WORD;
    wire ext_slow = (loc == OAD_LOC_EXT8) ||
                    (loc == OAD_LOC_EXT16 && odd_addr);
    wire ext_fast = loc == OAD_LOC_EXT16 && !odd_addr;
    wire mem_odd  = loc == OAD_LOC_IMEM && odd_addr;

    // Odd or narrow paths split words into bytes, hence the larger counts.
    assign cost.cycles =
        ext_slow ? (is_long ? COR_EIGHT : is_word ? COR_FOUR : COR_ONE) :
        ext_fast ? (is_long ? COR_TWO : COR_ONE) :
        mem_odd  ? (is_long ? COR_FOUR : is_word ? COR_TWO : COR_ZERO) :
                   COR_ZERO;
    assign cost.accesses =
        (ext_slow || mem_odd) ?
            (is_long ? ACC_FOUR : is_word ? ACC_TWO : ACC_ONE) :
            (is_long ? ACC_TWO : ACC_ONE);
endmodule

// ### verilog/oad_ea_decode.sv
// Combinational decoder of the 5-bit effective address code.
`timescale 1ns/1ns
module oad_ea_decode (
    input  wire logic [4:0]       ea_code,
    output oad_pkg::oad_ea_t      ea
);
    import oad_pkg::*;

    function automatic logic in_span(input logic [4:0] c,
                                     input logic [4:0] lo,
                                     input logic [4:0] hi);
        in_span = (c >= lo) && (c < hi);
    endfunction

    wire is_reg     = ea_code < EA_IND_FIRST;
    wire is_ind     = in_span(ea_code, EA_IND_FIRST, EA_POSTINC_FIRST);
    wire is_postinc = in_span(ea_code, EA_POSTINC_FIRST, EA_SHORT_DISPLACEMENT_FIRST);
    wire is_short_displacement   = in_span(ea_code, EA_SHORT_DISPLACEMENT_FIRST, EA_LONG_DISPLACEMENT_FIRST);
    wire is_long_displacement  = in_span(ea_code, EA_LONG_DISPLACEMENT_FIRST, EA_INDEX_FIRST);
    wire is_index   = in_span(ea_code, EA_INDEX_FIRST, EA_PC_DISP);
    wire is_pc      = ea_code == EA_PC_DISP;

    assign ea.reg_direct = is_reg;
    assign ea.mode = is_reg     ? OAD_MODE_REG      :
                     is_ind     ? OAD_MODE_INDIRECT :
                     is_postinc ? OAD_MODE_POSTINC  :
                     is_short_displacement   ? OAD_MODE_SHORT_DISPLACEMENT    :
                     is_long_displacement  ? OAD_MODE_LONG_DISPLACEMENT   :
                     is_index   ? OAD_MODE_INDEXED  :
                     is_pc      ? OAD_MODE_PC_DISP  : OAD_MODE_DIRECT;
    assign ea.ext_bytes = is_short_displacement ? EXT_ONE :
                          (is_long_displacement || ea_code >= EA_PC_DISP) ? EXT_TWO
                                                               : 2'h0;
    // Register direct cost comes from the instruction itself.
    assign ea.cycles = is_reg     ? 4'h0        :
                       is_ind     ? CYC_INDIRECT :
                       is_postinc ? CYC_POSTINC  :
                       is_short_displacement   ? CYC_DISP     :
                       is_long_displacement  ? CYC_DISP     :
                       is_index   ? CYC_INDEXED  :
                       is_pc      ? CYC_PC_DISP  : CYC_DIRECT;
    assign ea.rg = (is_postinc || is_index) ? RG_TWO :
                   (is_ind || is_short_displacement || is_long_displacement) ? RG_ONE : 3'h0;
    assign ea.byte_reg_n     = ea_code[2:0];
    assign ea.word_reg_n     = ea_code[2:0];
    assign ea.long_reg_n     = ea_code[2:1];
    assign ea.low_word_reg_n = is_index ? {1'b0, ea_code[0]} : ea_code[1:0];
    assign ea.index_used     = is_index;
endmodule

// ### verilog/oad_pkg.sv
// Shared types and constants for the operand address decode and cycle cost.
package oad_pkg;

    typedef enum logic [1:0] {
        OAD_BYTE = 2'h0,
        OAD_WORD = 2'h1,
        OAD_LONG = 2'h2
    } oad_width_t;

    typedef enum logic [1:0] {
        OAD_LOC_IREG  = 2'h0,
        OAD_LOC_IMEM  = 2'h1,
        OAD_LOC_EXT16 = 2'h2,
        OAD_LOC_EXT8  = 2'h3
    } oad_loc_t;

    typedef enum logic [2:0] {
        OAD_MODE_REG      = 3'h0,
        OAD_MODE_INDIRECT = 3'h1,
        OAD_MODE_POSTINC  = 3'h2,
        OAD_MODE_SHORT_DISPLACEMENT    = 3'h3,
        OAD_MODE_LONG_DISPLACEMENT   = 3'h4,
        OAD_MODE_INDEXED  = 3'h5,
        OAD_MODE_PC_DISP  = 3'h6,
        OAD_MODE_DIRECT   = 3'h7
    } oad_mode_t;

    typedef enum logic [1:0] {
        OAD_LH_ZERO = 2'h0,
        OAD_LH_SIGN = 2'h1,
        OAD_LH_KEEP = 2'h2
    } oad_lh_t;

    typedef enum logic [1:0] {
        OAD_AH_COPY  = 2'h0,
        OAD_AH_KEEP  = 2'h1,
        OAD_AH_CLEAR = 2'h2,
        OAD_AH_SIGN  = 2'h3
    } oad_ah_t;

    // First code of each addressing group after register direct, and a 3-bit register number.
    localparam logic [4:0] EA_IND_FIRST     = 5'h08;
    localparam logic [4:0] EA_POSTINC_FIRST = 5'h0C;
    localparam logic [4:0] EA_SHORT_DISPLACEMENT_FIRST   = 5'h10;
    localparam logic [4:0] EA_LONG_DISPLACEMENT_FIRST  = 5'h18;
    localparam logic [4:0] EA_INDEX_FIRST   = 5'h1C;
    localparam logic [4:0] EA_PC_DISP       = 5'h1E;
    localparam logic [4:0] EA_DIRECT        = 5'h1F;
    localparam logic [2:0] EA_INDEX_REG     = 3'h7;

    localparam logic [3:0] CYC_INDIRECT = 4'h2;
    localparam logic [3:0] CYC_POSTINC  = 4'h4;
    localparam logic [3:0] CYC_DISP     = 4'h2;
    localparam logic [3:0] CYC_INDEXED  = 4'h4;
    localparam logic [3:0] CYC_PC_DISP  = 4'h2;
    localparam logic [3:0] CYC_DIRECT   = 4'h1;
    localparam logic [2:0] RG_ONE       = 3'h1;
    localparam logic [2:0] RG_TWO       = 3'h2;
    localparam logic [1:0] EXT_ONE      = 2'h1;
    localparam logic [1:0] EXT_TWO      = 2'h2;

    // Access corrections: cycles and number of bus accesses.
    localparam logic [3:0] COR_ZERO      = 4'h0;
    localparam logic [3:0] COR_ONE       = 4'h1;
    localparam logic [3:0] COR_TWO       = 4'h2;
    localparam logic [3:0] COR_FOUR      = 4'h4;
    localparam logic [3:0] COR_EIGHT     = 4'h8;
    localparam logic [2:0] ACC_ONE       = 3'h1;
    localparam logic [2:0] ACC_TWO       = 3'h2;
    localparam logic [2:0] ACC_FOUR      = 3'h4;

    localparam logic [3:0] FETCH_IMEM_WORD  = 4'h2;
    localparam logic [3:0] FETCH_EXT16_WORD = 4'h3;
    localparam logic [3:0] FETCH_EXT8_BYTE  = 4'h3;

    localparam logic [23:0] IO_FIRST_ADDR = 24'h000000;
    localparam logic [23:0] IO_LAST_ADDR  = 24'h0000FF;
    localparam logic [31:0] ACC_RESET     = 32'h00000000;

    typedef struct packed {
        logic       reg_direct;
        oad_mode_t  mode;
        logic [1:0] ext_bytes;
        logic [3:0] cycles;
        logic [2:0] rg;
        logic [2:0] byte_reg_n;
        logic [2:0] word_reg_n;
        logic [1:0] long_reg_n;
        logic [1:0] low_word_reg_n;
        logic       index_used;
    } oad_ea_t;

    typedef struct packed {
        logic [3:0] cycles;
        logic [2:0] accesses;
    } oad_cost_t;

    typedef struct packed {
        logic [4:0]  ea_code;
        oad_width_t  width;
        oad_loc_t    loc;
        logic        odd_addr;
        logic        read_mod_write_class;
        logic [7:0]  instr_cycles;
        logic [3:0]  instr_rg;
        logic [7:0]  wait_cycles;
        logic [3:0]  fetch_bounds;
        logic        load_acc;
        oad_lh_t     lh;
        oad_ah_t     ah;
        logic [31:0] load_data;
        logic [7:0]  imm8;
        logic [7:0]  io_offset;
        logic        vct_long;
        logic [7:0]  vct_field;
    } oad_req_t;

endpackage

// ### verilog/oad_top.sv
// Operand decode, accumulator transfer and instruction cycle cost engine.
`timescale 1ns/1ns
module oad_top #(
    parameter int CYC_W          = 10,
    parameter int RG_TOTAL_W     = 16,
    parameter int INTERMIT_PER_RG = 1
) (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire logic                  req_valid,
    input  wire oad_pkg::oad_req_t     req,
    input  wire logic                  intermittent_en,
    output logic                       req_ready,
    output oad_pkg::oad_ea_t           ea_info,
    output logic [CYC_W-1:0]           total_cycles,
    output logic [4:0]                 total_rg,
    output logic [3:0]                 total_accesses,
    output logic                       rmw_active,
    output logic [31:0]                acc,
    output logic [23:0]                io_addr,
    output logic [15:0]                sign_ext_short_imm,
    output logic [7:0]                 vector_num,
    output logic                       busy,
    output logic                       done,
    output logic [RG_TOTAL_W-1:0]      reg_access_count
);
    import oad_pkg::*;

    // Refuse sizes that the cycle and tally counters cannot hold.
    if (CYC_W < 8 || CYC_W > 16) begin : g_bad_cyc_w
        $error("CYC_W must lie between 8 and 16");
    end
    if (RG_TOTAL_W < 5 || INTERMIT_PER_RG < 0 ||
        INTERMIT_PER_RG > 8) begin : g_bad_rg
        $error("RG_TOTAL_W or INTERMIT_PER_RG out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_DONE = 3'b100
    } oad_state_t;

    oad_state_t      state;
    oad_state_t      next_state;
    oad_cost_t       acc_cost;
    logic [CYC_W-1:0] remain;

    // Decode is purely combinational so the ea fields track ea_code
    // without latency.
    oad_ea_decode u_decode (
        .ea_code (req.ea_code),
        .ea      (ea_info)
    );

    oad_access_cost u_cost (
        .width    (req.width),
        .loc      (req.loc),
        .odd_addr (req.odd_addr),
        .cost     (acc_cost)
    );

    wire accept  = clk_en && req_valid && state == ST_IDLE;
    wire mem_op  = !ea_info.reg_direct;
    wire is_ext  = req.loc == OAD_LOC_EXT16 || req.loc == OAD_LOC_EXT8;
    // A READ_MOD_WRITE_CLASS memory operand is touched twice, once to read and once to write.
    wire rmw_op  = req.read_mod_write_class && mem_op;
    wire [CYC_W-1:0] ea_cyc = mem_op ? CYC_W'(ea_info.cycles) : '0;
    wire [CYC_W-1:0] cor_one = CYC_W'(acc_cost.cycles);
    wire [CYC_W-1:0] cor_cyc = rmw_op ? CYC_W'({cor_one, 1'b0})
                                      : cor_one;
    // Waits only arise on the external bus.
    wire [CYC_W-1:0] wait_cyc = is_ext ? CYC_W'(req.wait_cycles)
                                       : '0;
    wire [3:0] fetch_unit = req.loc == OAD_LOC_IMEM  ? FETCH_IMEM_WORD  :
                            req.loc == OAD_LOC_EXT16 ? FETCH_EXT16_WORD :
                            req.loc == OAD_LOC_EXT8  ? FETCH_EXT8_BYTE  :
                                                       4'h0;
    wire [CYC_W-1:0] fetch_cyc = CYC_W'(fetch_unit * req.fetch_bounds);
    wire [4:0] rg_sum = 5'(req.instr_rg) +
                        (mem_op ? 5'(ea_info.rg) : 5'h0);
    wire [CYC_W-1:0] intermit_cyc =
        intermittent_en ? CYC_W'(rg_sum * 5'(INTERMIT_PER_RG)) : '0;
    wire [CYC_W-1:0] sum_cyc = CYC_W'(req.instr_cycles) + ea_cyc +
                               cor_cyc + wait_cyc + fetch_cyc + intermit_cyc;
    // A zero figure still occupies one cycle so done always pulses.
    wire [CYC_W-1:0] next_total = (sum_cyc == '0) ? CYC_W'(1) : sum_cyc;
    wire [3:0] next_accesses = rmw_op ? 4'({acc_cost.accesses, 1'b0})
                                      : 4'(acc_cost.accesses);

    // Accumulator transfer paths.
    wire [15:0] acc_low = acc[15:0];
    wire [7:0] mid_byte = req.lh == OAD_LH_ZERO ? 8'h00 :
                          req.lh == OAD_LH_SIGN ? {8{req.load_data[7]}}
                                                : acc[15:8];
    wire [15:0] next_low = req.width == OAD_BYTE ?
                               {mid_byte, req.load_data[7:0]} :
                               req.load_data[15:0];
    wire [15:0] next_high =
        req.width == OAD_LONG    ? req.load_data[31:16] :
        req.ah == OAD_AH_COPY    ? acc_low :
        req.ah == OAD_AH_CLEAR   ? 16'h0000 :
        req.ah == OAD_AH_SIGN    ? {16{next_low[15]}} :
                                   acc[31:16];

    wire [23:0] next_io = IO_FIRST_ADDR | {16'h0000, req.io_offset};
    wire [15:0] next_sext = {{8{req.imm8[7]}}, req.imm8};
    wire [7:0] next_vector = req.vct_long ? req.vct_field
                                          : {4'h0, req.vct_field[3:0]};

    assign req_ready = state == ST_IDLE;
    assign busy      = state != ST_IDLE;
    assign done      = state == ST_DONE;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (accept)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (remain == CYC_W'(1))
                    next_state = ST_DONE;
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state  <= ST_IDLE;
            remain <= '0;
        end else if (clk_en) begin
            state <= next_state;
            if (accept)
                remain <= next_total;
            else if (state == ST_RUN)
                remain <= remain - CYC_W'(1);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            total_cycles   <= '0;
            total_rg       <= '0;
            total_accesses <= '0;
            rmw_active     <= 1'b0;
            io_addr        <= IO_FIRST_ADDR;
            sign_ext_short_imm <= '0;
            vector_num     <= '0;
        end else if (accept) begin
            total_cycles   <= next_total;
            total_rg       <= rg_sum;
            total_accesses <= next_accesses;
            rmw_active     <= rmw_op;
            io_addr        <= next_io;
            sign_ext_short_imm <= next_sext;
            vector_num     <= next_vector;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            acc <= ACC_RESET;
        else if (accept && req.load_acc)
            acc <= {next_high, next_low};
    end

    // Running total wraps; software reads it as a free-running tally.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            reg_access_count <= '0;
        else if (accept)
            reg_access_count <= reg_access_count +
                                RG_TOTAL_W'(rg_sum);
    end

    // Helper: cycles spent since the request was taken.
    logic [CYC_W-1:0] elapsed;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            elapsed <= '0;
        else if (clk_en)
            elapsed <= accept ? CYC_W'(0) :
                       (state == ST_RUN) ? elapsed + CYC_W'(1) : elapsed;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_reg_direct: assert property (
        req.ea_code < 5'h08 |-> ea_info.reg_direct && ea_info.rg == 3'h0
        && ea_info.long_reg_n == req.ea_code[2:1])
        else $error("register direct decode wrong");
    chk_ea_indirect: assert property (
        req.ea_code inside {[5'h08:5'h0B]} |-> ea_info.cycles == 4'h2
        && ea_info.rg == 3'h1 && ea_info.ext_bytes == 2'h0)
        else $error("indirect decode wrong");
    chk_ea_postinc: assert property (
        req.ea_code inside {[5'h0C:5'h0F]} |-> ea_info.cycles == 4'h4
        && ea_info.rg == 3'h2 && ea_info.ext_bytes == 2'h0)
        else $error("post-increment decode wrong");
    chk_ea_short_displacement: assert property (
        req.ea_code inside {[5'h10:5'h17]} |-> ea_info.ext_bytes == 2'h1
        && ea_info.cycles == 4'h2 && ea_info.word_reg_n == req.ea_code[2:0])
        else $error("8-bit displacement decode wrong");
    chk_ea_long_displacement: assert property (
        req.ea_code inside {[5'h18:5'h1B]} |-> ea_info.ext_bytes == 2'h2
        && ea_info.rg == 3'h1 && ea_info.cycles == 4'h2)
        else $error("16-bit displacement decode wrong");
    chk_ea_indexed: assert property (
        req.ea_code inside {5'h1C, 5'h1D} |-> ea_info.index_used
        && ea_info.cycles == 4'h4 && ea_info.rg == 3'h2)
        else $error("indexed decode wrong");
    chk_pc_direct: assert property (
        req.ea_code >= 5'h1E |-> ea_info.ext_bytes == 2'h2
        && ea_info.rg == 3'h0 && ea_info.cycles ==
        (req.ea_code == 5'h1E ? 4'h2 : 4'h1))
        else $error("pc or direct decode wrong");
    chk_byte_lh: assert property (
        accept && req.load_acc && req.width == OAD_BYTE
        && req.lh == OAD_LH_ZERO |=> acc[15:8] == 8'h00
        && acc[7:0] == $past(req.load_data[7:0]))
        else $error("byte load middle byte wrong");
    chk_ah_copy: assert property (
        accept && req.load_acc && req.width != OAD_LONG
        && req.ah == OAD_AH_COPY |=> acc[31:16] == $past(acc[15:0]))
        else $error("upper half copy wrong");
    chk_odd_word: assert property (
        req.loc == OAD_LOC_IMEM && req.odd_addr && req.width == OAD_WORD
        |-> acc_cost.cycles == 4'h2 && acc_cost.accesses == 3'h2)
        else $error("internal odd word correction wrong");
    chk_slow_long: assert property (
        req.loc == OAD_LOC_EXT8 && req.width == OAD_LONG
        |-> acc_cost.cycles == 4'h8 && acc_cost.accesses == 3'h4)
        else $error("narrow bus long correction wrong");
    chk_cost_count: assert property (
        $rose(done) |-> elapsed == total_cycles)
        else $error("instruction length differs from cost");
    chk_io_range: assert property (
        accept |=> io_addr == {16'h0000, $past(req.io_offset)})
        else $error("short I/O address out of range");
    chk_sext_imm: assert property (
        sign_ext_short_imm[15:8] == {8{sign_ext_short_imm[7]}})
        else $error("immediate sign extension wrong");
    chk_ireg_free: assert property (
        req.loc == OAD_LOC_IREG |-> acc_cost.cycles == 4'h0)
        else $error("register access correction not zero");
    chk_ext_fast: assert property (
        req.loc == OAD_LOC_EXT16 && !req.odd_addr |-> acc_cost.cycles
        == (req.width == OAD_LONG ? 4'h2 : 4'h1))
        else $error("even wide bus correction wrong");
    chk_fetch_unit: assert property (
        fetch_unit == (req.loc == OAD_LOC_IREG ? 4'h0 :
        req.loc == OAD_LOC_IMEM ? 4'h2 : 4'h3))
        else $error("program fetch correction wrong");
    chk_long_load: assert property (
        accept && req.load_acc && req.width == OAD_LONG
        |=> acc == $past(req.load_data))
        else $error("long load wrong");
    chk_byte_sign: assert property (
        accept && req.load_acc && req.width == OAD_BYTE && req.lh ==
        OAD_LH_SIGN |=> acc[15:8] == {8{$past(req.load_data[7])}})
        else $error("byte load sign extension wrong");
    chk_ah_clear: assert property (
        accept && req.load_acc && req.width != OAD_LONG
        && req.ah == OAD_AH_CLEAR |=> acc[31:16] == 16'h0000)
        else $error("upper half clear wrong");
    chk_rg_tally: assert property (
        accept |=> reg_access_count ==
        $past(reg_access_count) + RG_TOTAL_W'(total_rg))
        else $error("register access tally wrong");
endmodule
